// ### logic/ppm_defs.svh
// Constant definitions for the port pin function multiplexer
`ifndef PPM_DEFS_SVH
`define PPM_DEFS_SVH

// ----------------------------------------------------------------
// Port widths
// ----------------------------------------------------------------
`define PPM_BYTE_W 8
`define PPM_P6_W 5
`define PPM_DISP_LO_W 24
`define PPM_DISP_HI_W 29

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PPM_RST_BYTE 8'h00
`define PPM_RST_P6 5'h00
`define PPM_RST_DLO 24'h00_0000

// ----------------------------------------------------------------
// Fixed alternate bit positions
// ----------------------------------------------------------------
`define PPM_P0_BUZ_BIT 7
`define PPM_P0_TMR_BIT 2
`define PPM_P6_EC_BIT 3
`define PPM_P6_PWM_BIT 4

// Synchroniser to register stage count on pin inputs
`define PPM_SYNC_LAT 3

`endif

// ### logic/ppm_pkg.sv
// Types shared by the port pin function multiplexer
`include "ppm_defs.svh"

package ppm_pkg;

  // Valid edge choice for an external interrupt input
  typedef enum logic [1:0] {
    PPM_EDGE_OFF  = 2'b00,
    PPM_EDGE_RISE = 2'b01,
    PPM_EDGE_FALL = 2'b10,
    PPM_EDGE_BOTH = 2'b11
  } ppm_edge_e;

  // All state of the edge detector
  typedef struct packed {
    logic prev; // Level seen last cycle
    logic req;  // Request pulse
  } ppm_edge_s;

  // All state of the pin multiplexer except the reset synchroniser and the edge detectors
  typedef struct packed {
    logic [7:0] p0_s1, p0_s2, p2_s1, p2_s2, p5_s1, p5_s2;
    logic [4:0] p6_s1, p6_s2;
    logic [7:0] p0_out, p0_oe, p0_pu, p0_rd;
    logic [7:0] p2_out, p2_oe, p2_pu, p2_rd;
    logic [7:0] p3_oe, p4_oe, p5_oe, p5_rd;
    logic [4:0] p6_oe, p6_rd;
    logic [23:0] disp;
    logic tmr_in, s3_clk, s1_din, s1_clk, ec_in;
    logic [6:0] conv;
  } ppm_state_s;

endpackage

// ### logic/ppm_edge.sv
// Edge detector raising one-cycle external interrupt requests
`timescale 1ns/1ps
`default_nettype none

module ppm_edge
  import ppm_pkg::*;
(
  // Clock and synchronised reset
  input wire logic mclk,
  input wire logic rst_ok,
  // Control
  input wire logic enable,
  input wire logic [1:0] mode,
  // Synchronised pin level
  input wire logic level,
  // Request pulse
  output logic req
);

  ppm_edge_s q; // Registered state
  ppm_edge_s n; // Next state

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Tracking level even while disabled avoids a false edge on enable
  always_comb begin
    n = q;
    n.prev = level;
    n.req = enable & ((level & ~q.prev & mode[0]) | (~level & q.prev & mode[1]));
  end

  // State register
  always_ff @(posedge mclk or negedge rst_ok) begin
    if (!rst_ok) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign req = q.req;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_rise;
    !level ##1 level;
  endsequence

  sequence s_fall;
    level ##1 !level;
  endsequence

  chk_edge_rise: assert property (@(posedge mclk) disable iff (!rst_ok)
    (s_rise ##0 (enable && mode[0])) |=> req)
    else $error("rising edge request missing");

  chk_edge_fall: assert property (@(posedge mclk) disable iff (!rst_ok)
    (s_fall ##0 (enable && !mode[1])) |=> !req)
    else $error("falling edge raised request when not selected");

  chk_edge_fall_req: assert property (@(posedge mclk) disable iff (!rst_ok)
    (s_fall ##0 (enable && mode[1])) |=> req)
    else $error("falling edge request missing");

endmodule // ppm_edge

`default_nettype wire

// ### logic/ppm_pin_mux.sv
// Per-bit port pin multiplexer for ports 0, 2, 3, 4, 5, 6 and display lines
`timescale 1ns/1ps
`default_nettype none
`include "ppm_defs.svh"

// Summary of operation
// - Each port 0 bit chooses port or alternate
// - Port 0 direction bits set input/output
// - Port 0 input pull-up from option bit
// - Port 0 alternate: irq, timer, converter, buzzer
// - Interrupt edge: rising, falling or both
// - Port 2 direction and pull-up per bit
// - Port 2 alternate: serial 3, converter, serial 1
// - Ports 3, 4 open-drain outputs or display
// - Port 5 open-drain I/O or display
// - Port 6 I/O, display, counter, PWM
// - Low reset pin holds everything reset
// - Display lines 0-23 display driven whenever out of reset
module ppm_pin_mux
  import ppm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Port 0 control
  input wire logic [7:0] port0_direction,
  input wire logic [7:0] port0_pullup_option,
  input wire logic [7:0] port0_alt,
  input wire logic [7:0] port0_latch,
  input wire logic [1:0] ext_irq_edge_0,
  input wire logic [1:0] ext_irq_edge_1,
  // Port 0 pins
  input wire logic [7:0] p0_pin_in,
  output logic [7:0] p0_pin_out,
  output logic [7:0] p0_pin_oe,
  output logic [7:0] p0_pin_pullup,
  output logic [7:0] port0_read,
  // Port 0 peripherals
  input wire logic buzzer_out,
  output logic ext_irq_in_0,
  output logic ext_irq_in_1,
  output logic remote_timer_in,
  output logic [6:0] conv_in,
  // Port 2 control
  input wire logic [7:0] port2_direction,
  input wire logic [7:0] port2_pullup_option,
  input wire logic [7:0] port2_alt,
  input wire logic [7:0] port2_latch,
  // Port 2 pins
  input wire logic [7:0] p2_pin_in,
  output logic [7:0] p2_pin_out,
  output logic [7:0] p2_pin_oe,
  output logic [7:0] p2_pin_pullup,
  output logic [7:0] port2_read,
  // Serial channels
  input wire logic serial3_clock_out,
  input wire logic serial3_clock_oe,
  output logic serial3_clock,
  input wire logic serial3_data_out,
  input wire logic serial1_data_out,
  output logic serial1_data_in,
  input wire logic serial1_clock_out,
  input wire logic serial1_clock_oe,
  output logic serial1_clock,
  // Ports 3 and 4
  input wire logic [7:0] port3_alt,
  input wire logic [7:0] port3_latch,
  output logic [7:0] p3_pin_oe,
  input wire logic [7:0] port4_alt,
  input wire logic [7:0] port4_latch,
  output logic [7:0] p4_pin_oe,
  // Port 5
  input wire logic [7:0] port5_direction,
  input wire logic [7:0] port5_alt,
  input wire logic [7:0] port5_latch,
  input wire logic [7:0] p5_pin_in,
  output logic [7:0] p5_pin_oe,
  output logic [7:0] port5_read,
  // Port 6
  input wire logic [4:0] port6_direction,
  input wire logic [4:0] port6_alt,
  input wire logic [4:0] port6_latch,
  input wire logic [4:0] p6_pin_in,
  output logic [4:0] p6_pin_oe,
  output logic [4:0] port6_read,
  input wire logic pwm_enable,
  input wire logic pwm_out_1,
  output logic event_count_in_0,
  // Display driver
  input wire logic [23:0] display_lo,
  input wire logic [28:0] display_hi,
  output logic [23:0] display_line
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta; // First stage, read only by rst_ok
  logic rst_ok;   // Released reset used everywhere else

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_ok <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_ok <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Per-bit select: alternate value where sel is set, else port value
  function automatic logic [7:0] pick(input logic [7:0] sel,
                                      input logic [7:0] alt_v,
                                      input logic [7:0] port_v);
    pick = (sel & alt_v) | (~sel & port_v);
  endfunction

  // Read-back: output bits show the latch, input bits the pin
  function automatic logic [7:0] rdback(input logic [7:0] dir,
                                        input logic [7:0] latch,
                                        input logic [7:0] pin);
    rdback = (dir & latch) | (~dir & pin);
  endfunction

  ppm_state_s q; // Registered state
  ppm_state_s n; // Next state
  logic [7:0] p2_alt_out; // Serial drive values on port 2
  logic [7:0] p2_alt_oe;  // Serial drive enables on port 2
  logic [7:0] p6_alt;     // Display or PWM drive on port 6
  logic [7:0] p6_rd_w;    // Widened port 6 read
  logic [7:0] p6_oe_w;    // Widened port 6 drive enable

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = q;
    // Two-stage synchronisers on every pin input
    n.p0_s1 = p0_pin_in;
    n.p0_s2 = q.p0_s1;
    n.p2_s1 = p2_pin_in;
    n.p2_s2 = q.p2_s1;
    n.p5_s1 = p5_pin_in;
    n.p5_s2 = q.p5_s1;
    n.p6_s1 = p6_pin_in;
    n.p6_s2 = q.p6_s1;

    n.p0_oe = pick(port0_alt, 8'h80, port0_direction);
    n.p0_out = pick(port0_alt, {buzzer_out, 7'h00}, port0_latch);
    n.p0_pu = ~port0_alt & ~port0_direction & port0_pullup_option;
    n.p0_rd = rdback(port0_direction, port0_latch, q.p0_s2);

    // timer and converter inputs, gated by mode
    n.tmr_in = port0_alt[`PPM_P0_TMR_BIT] & q.p0_s2[`PPM_P0_TMR_BIT];
    n.conv = {port2_alt[4:2] & q.p2_s2[4:2], port0_alt[6:3] & q.p0_s2[6:3]};

    p2_alt_out = {serial1_clock_out, 1'b0, serial1_data_out, 3'b000,
                  serial3_data_out, serial3_clock_out};
    p2_alt_oe = {serial1_clock_oe, 1'b0, 1'b1, 3'b000, 1'b1, serial3_clock_oe};
    n.p2_out = pick(port2_alt, p2_alt_out, port2_latch);
    n.p2_oe = pick(port2_alt, p2_alt_oe, port2_direction);
    n.p2_pu = ~port2_alt & ~port2_direction & port2_pullup_option;
    n.p2_rd = rdback(port2_direction, port2_latch, q.p2_s2);
    n.s3_clk = port2_alt[0] & q.p2_s2[0];
    n.s1_din = port2_alt[6] & q.p2_s2[6];
    n.s1_clk = port2_alt[7] & q.p2_s2[7];

    // open-drain output ports 3 and 4
    n.p3_oe = pick(port3_alt, display_hi[7:0], port3_latch);
    n.p4_oe = pick(port4_alt, display_hi[15:8], port4_latch);

    n.p5_oe = pick(port5_alt, display_hi[23:16], port5_direction & port5_latch);
    n.p5_rd = rdback(port5_direction, port5_latch, q.p5_s2);

    // port 6: PWM overrides display on bit 4
    p6_alt = {3'b000, display_hi[28:24]};
    if (pwm_enable) begin
      p6_alt[`PPM_P6_PWM_BIT] = pwm_out_1;
    end
    p6_oe_w = pick({3'b000, port6_alt}, p6_alt,
                   {3'b000, port6_direction & port6_latch});
    n.p6_oe = p6_oe_w[4:0];
    p6_rd_w = rdback({3'b000, port6_direction}, {3'b000, port6_latch},
                     {3'b000, q.p6_s2});
    n.p6_rd = p6_rd_w[4:0];
    n.ec_in = q.p6_s2[`PPM_P6_EC_BIT];

    n.disp = display_lo;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // whole state reset
  always_ff @(posedge mclk or negedge rst_ok) begin
    if (!rst_ok) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // External interrupt edge detectors
  // ----------------------------------------------------------------
  // edge choice per input
  ppm_edge u_edge0 (
    .mclk(mclk),
    .rst_ok(rst_ok),
    .enable(port0_alt[0]),
    .mode(ext_irq_edge_0),
    .level(q.p0_s2[0]),
    .req(ext_irq_in_0)
  );

  ppm_edge u_edge1 (
    .mclk(mclk),
    .rst_ok(rst_ok),
    .enable(port0_alt[1]),
    .mode(ext_irq_edge_1),
    .level(q.p0_s2[1]),
    .req(ext_irq_in_1)
  );

  // ----------------------------------------------------------------
  // Outputs, all straight from state
  // ----------------------------------------------------------------
  assign p0_pin_out = q.p0_out;
  assign p0_pin_oe = q.p0_oe;
  assign p0_pin_pullup = q.p0_pu;
  assign port0_read = q.p0_rd;
  assign remote_timer_in = q.tmr_in;
  assign conv_in = q.conv;
  assign p2_pin_out = q.p2_out;
  assign p2_pin_oe = q.p2_oe;
  assign p2_pin_pullup = q.p2_pu;
  assign port2_read = q.p2_rd;
  assign serial3_clock = q.s3_clk;
  assign serial1_data_in = q.s1_din;
  assign serial1_clock = q.s1_clk;
  assign p3_pin_oe = q.p3_oe;
  assign p4_pin_oe = q.p4_oe;
  assign p5_pin_oe = q.p5_oe;
  assign port5_read = q.p5_rd;
  assign p6_pin_oe = q.p6_oe;
  assign port6_read = q.p6_rd;
  assign event_count_in_0 = q.ec_in;
  assign display_line = q.disp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_ok);

  // Antecedents also need rst_ok sampled high: on the release edge the state
  // register still sees reset, so the cycle after it shows no input yet
  // Input direction held long enough to cover the sync delay
  sequence s_p0_in_hold;
    (rst_ok && port0_direction == 8'h00) [*4];
  endsequence

  chk_mode_indep: assert property (
    (rst_ok && port0_alt == 8'h80 && port0_direction == 8'h7f) |=> p0_pin_oe == 8'hff)
    else $error("port 0 bits not set independently");

  chk_p0_dir: assert property (
    (rst_ok && port0_alt == 8'h00) |=> p0_pin_oe == $past(port0_direction))
    else $error("port 0 enable does not follow direction");

  chk_p0_pullup: assert property (
    (rst_ok && port0_alt == 8'h00) |=>
      p0_pin_pullup == ($past(port0_pullup_option) & ~$past(port0_direction)))
    else $error("port 0 pull-up wrong");

  chk_alt_buzzer: assert property (
    (rst_ok && port0_alt[7]) |=> p0_pin_oe[7] && p0_pin_out[7] == $past(buzzer_out))
    else $error("buzzer not driven on bit 7");

  chk_p2_dir: assert property (
    (rst_ok && port2_alt == 8'h00) |=> p2_pin_oe == $past(port2_direction)
      && p2_pin_pullup == ($past(port2_pullup_option) & ~$past(port2_direction)))
    else $error("port 2 direction or pull-up wrong");

  chk_p2_serial: assert property (
    (rst_ok && port2_alt[1]) |=> p2_pin_oe[1] && p2_pin_out[1] == $past(serial3_data_out))
    else $error("serial 3 data not driven");

  chk_p3_drive: assert property (
    (rst_ok && port3_alt == 8'h00) |=> p3_pin_oe == $past(port3_latch))
    else $error("port 3 does not drive its latch");

  chk_p5_disp: assert property (
    (rst_ok && port5_alt[0]) |=> p5_pin_oe[0] == $past(display_hi[16]))
    else $error("port 5 display line wrong");

  chk_p6_pwm: assert property (
    (rst_ok && port6_alt[4] && pwm_enable) |=> p6_pin_oe[4] == $past(pwm_out_1))
    else $error("PWM not on port 6 bit 4");

  chk_reset_hold: assert property (@(posedge mclk) disable iff (1'b0)
    !rst_ok |=> (p0_pin_oe == 8'h00 && p2_pin_oe == 8'h00 && p5_pin_oe == 8'h00))
    else $error("pins driven during reset");

  chk_disp_lines: assert property (
    rst_ok |=> display_line == $past(display_lo))
    else $error("dedicated display lines not driven");

  chk_read_back: assert property (
    s_p0_in_hold |-> port0_read == $past(p0_pin_in, 3))
    else $error("input read does not show pin");

endmodule // ppm_pin_mux

`default_nettype wire

// ### tb/ppm_pin_board.sv
// Board-side model of the pins and outside drivers around the port multiplexer
`timescale 1ns/1ps
`default_nettype none

module ppm_pin_board (
  // Drive from the block
  input wire logic [7:0] p0_out,
  input wire logic [7:0] p0_oe,
  input wire logic [7:0] p0_pu,
  input wire logic [7:0] p2_out,
  input wire logic [7:0] p2_oe,
  input wire logic [7:0] p2_pu,
  input wire logic [7:0] p5_oe,
  input wire logic [4:0] p6_oe,
  // Outside drivers, also the pull-down level on open-drain pins
  input wire logic [7:0] ext0,
  input wire logic [7:0] ext2,
  input wire logic [7:0] ext5,
  input wire logic [4:0] ext6,
  // Resolved pin levels
  output logic [7:0] p0_pin,
  output logic [7:0] p2_pin,
  output logic [7:0] p5_pin,
  output logic [4:0] p6_pin
);
  // ---------------------------------------------
  // Pin resolution
  // ---------------------------------------------
  // Push-pull pins: own drive wins, then pull-up, then the outside level
  assign p0_pin = (p0_oe & p0_out) | (~p0_oe & (p0_pu | ext0));
  assign p2_pin = (p2_oe & p2_out) | (~p2_oe & (p2_pu | ext2));
  // Open-drain pins only pull high; otherwise the outside level shows
  assign p5_pin = p5_oe | ext5;
  assign p6_pin = p6_oe | ext6;
endmodule // ppm_pin_board

`default_nettype wire

// ### tb/tb_ppm_pin_mux.sv
// Self-checking testbench for the port pin multiplexer
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end

module tb_ppm_pin_mux;
  import ppm_pkg::*;
  // ---------------------------------------------
  // Signals, named as the block's ports
  // ---------------------------------------------
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] port0_direction, port0_pullup_option, port0_alt, port0_latch, p0_pin_in;
  logic [7:0] p0_pin_out, p0_pin_oe, p0_pin_pullup, port0_read;
  logic [1:0] ext_irq_edge_0, ext_irq_edge_1;
  logic buzzer_out, ext_irq_in_0, ext_irq_in_1, remote_timer_in;
  logic [6:0] conv_in;
  logic [7:0] port2_direction, port2_pullup_option, port2_alt, port2_latch, p2_pin_in;
  logic [7:0] p2_pin_out, p2_pin_oe, p2_pin_pullup, port2_read;
  logic serial3_clock_out, serial3_clock_oe, serial3_clock, serial3_data_out;
  logic serial1_data_out, serial1_data_in, serial1_clock_out, serial1_clock_oe;
  logic serial1_clock;
  logic [7:0] port3_alt, port3_latch, p3_pin_oe, port4_alt, port4_latch, p4_pin_oe;
  logic [7:0] port5_direction, port5_alt, port5_latch, p5_pin_in, p5_pin_oe, port5_read;
  logic [4:0] port6_direction, port6_alt, port6_latch, p6_pin_in, p6_pin_oe, port6_read;
  logic pwm_enable, pwm_out_1, event_count_in_0;
  logic [23:0] display_lo, display_line;
  logic [28:0] display_hi;
  // Outside levels seen on pins that nobody drives
  logic [7:0] ext0, ext2, ext5;
  logic [4:0] ext6;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int n0, n1;

  // 40 MHz clock
  always #12.5 mclk = ~mclk;

  ppm_pin_mux dut_u (
    .mclk, .rstn, .port0_direction, .port0_pullup_option, .port0_alt, .port0_latch,
    .ext_irq_edge_0, .ext_irq_edge_1, .p0_pin_in, .p0_pin_out, .p0_pin_oe, .p0_pin_pullup,
    .port0_read, .buzzer_out, .ext_irq_in_0, .ext_irq_in_1, .remote_timer_in, .conv_in,
    .port2_direction, .port2_pullup_option, .port2_alt, .port2_latch, .p2_pin_in,
    .p2_pin_out, .p2_pin_oe, .p2_pin_pullup, .port2_read, .serial3_clock_out,
    .serial3_clock_oe, .serial3_clock, .serial3_data_out, .serial1_data_out,
    .serial1_data_in, .serial1_clock_out, .serial1_clock_oe, .serial1_clock, .port3_alt,
    .port3_latch, .p3_pin_oe, .port4_alt, .port4_latch, .p4_pin_oe, .port5_direction,
    .port5_alt, .port5_latch, .p5_pin_in, .p5_pin_oe, .port5_read, .port6_direction,
    .port6_alt, .port6_latch, .p6_pin_in, .p6_pin_oe, .port6_read, .pwm_enable, .pwm_out_1,
    .event_count_in_0, .display_lo, .display_hi, .display_line
  );

  ppm_pin_board board_u (
    .p0_out(p0_pin_out), .p0_oe(p0_pin_oe), .p0_pu(p0_pin_pullup), .p2_out(p2_pin_out),
    .p2_oe(p2_pin_oe), .p2_pu(p2_pin_pullup), .p5_oe(p5_pin_oe), .p6_oe(p6_pin_oe),
    .ext0(ext0), .ext2(ext2), .ext5(ext5), .ext6(ext6), .p0_pin(p0_pin_in),
    .p2_pin(p2_pin_in), .p5_pin(p5_pin_in), .p6_pin(p6_pin_in)
  );

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  // Count request cycles mid-cycle, away from the launching edge
  always @(negedge mclk) begin
    if (ext_irq_in_0 === 1'b1) n0++;
    if (ext_irq_in_1 === 1'b1) n1++;
  end

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      summarize();
    end
  end

  // Inputs move a fixed 2 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_reset();
    display_lo = 24'h5A_C3E1;
    port0_direction = 8'hFF;
    step(8);
    `CHK(display_line, 24'h00_0000)
    `CHK(p0_pin_oe, 8'h00)
    rstn = 1'b1;
    step(4);
    `CHK(display_line, 24'h5A_C3E1)
    port0_direction = 8'h00;
  endtask

  task automatic t_port0();
    port0_direction = 8'h0F;
    port0_latch = 8'hA5;
    port0_pullup_option = 8'h3C;
    ext0 = 8'h81;
    step(5);
    `CHK(p0_pin_oe, 8'h0F)
    `CHK(p0_pin_out & 8'h0F, 8'h05)
    `CHK(p0_pin_pullup, 8'h30)
    `CHK(port0_read, 8'hB5)
    port0_latch = 8'h5A;
    step(1);
    `CHK(p0_pin_out & 8'h0F, 8'h0A)
  endtask

  task automatic t_port0_alt();
    port0_direction = 8'h00;
    port0_alt = 8'hF4;
    port0_pullup_option = 8'hFF;
    buzzer_out = 1'b1;
    ext0 = 8'h5C;
    step(5);
    `CHK(p0_pin_oe[7], 1'b1)
    `CHK(p0_pin_out[7], 1'b1)
    `CHK(p0_pin_pullup, 8'h0B)
    `CHK(remote_timer_in, 1'b1)
    `CHK(conv_in[3:0], 4'hA)
    buzzer_out = 1'b0;
    step(1);
    `CHK(p0_pin_out[7], 1'b0)
    // Bit 7 alternate while bits 6..0 are port outputs
    port0_alt = 8'h80;
    port0_direction = 8'h7F;
    step(1);
    `CHK(p0_pin_oe, 8'hFF)
    port0_direction = 8'h00;
  endtask

  task automatic t_irq();
    int exp_n;
    for (int m = 0; m < 5; m++) begin
      port0_alt = (m < 4) ? 8'h03 : 8'h00;
      ext_irq_edge_0 = m[1:0];
      ext_irq_edge_1 = (m < 4) ? m[1:0] : 2'b11;
      ext0 = 8'h00;
      step(6);
      n0 = 0;
      n1 = 0;
      ext0 = 8'h03;
      step(8);
      ext0 = 8'h00;
      step(8);
      exp_n = (m == 4) ? 0 : (m == 3) ? 2 : (m == 0) ? 0 : 1;
      `CHK(n0, exp_n)
      `CHK(n1, exp_n)
    end
  endtask

  task automatic t_port2();
    port2_direction = 8'hF0;
    port2_pullup_option = 8'h0F;
    port2_latch = 8'h30;
    ext2 = 8'h00;
    step(5);
    `CHK(p2_pin_oe, 8'hF0)
    `CHK(p2_pin_pullup, 8'h0F)
    `CHK(port2_read, 8'h3F)
    port2_alt = 8'hFF;
    {serial3_clock_out, serial3_clock_oe, serial3_data_out, serial1_data_out} = 4'hF;
    ext2 = 8'hD4;
    step(5);
    `CHK(p2_pin_oe & 8'h23, 8'h23)
    `CHK(p2_pin_out & 8'h23, 8'h23)
    `CHK(p2_pin_pullup, 8'h00)
    `CHK({serial3_clock, serial1_data_in, serial1_clock}, 3'b111)
    `CHK(conv_in[6:4], 3'b101)
  endtask

  task automatic t_open_drain();
    display_hi = {5'h15, 8'hC3, 8'h3C, 8'h96};
    {port3_alt, port3_latch, port4_alt, port4_latch} = 32'h0FA5_F05A;
    {port5_alt, port5_direction, port5_latch, ext5} = 32'h0FF0_CC21;
    {port6_alt, port6_direction, port6_latch, ext6} = 20'h8_0428;
    {pwm_enable, pwm_out_1} = 2'b11;
    step(5);
    `CHK(p3_pin_oe, 8'hA6)
    `CHK(p4_pin_oe, 8'h3A)
    `CHK(p5_pin_oe, 8'hC3)
    `CHK(port5_read, 8'hC3)
    `CHK(p6_pin_oe, 5'h11)
    `CHK(port6_read, 5'h19)
    `CHK(event_count_in_0, 1'b1)
    display_hi[28:24] = 5'h05;
    pwm_enable = 1'b0;
    step(1);
    `CHK(p6_pin_oe, 5'h01)
    rstn = 1'b0;
    #3;
    `CHK(p3_pin_oe, 8'h00)
    `CHK(display_line, 24'h00_0000)
  endtask

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    {port0_direction, port0_pullup_option, port0_alt, port0_latch, port2_direction} = '0;
    {port2_pullup_option, port2_alt, port2_latch, port3_alt, port3_latch} = '0;
    {port4_alt, port4_latch, port5_direction, port5_alt, port5_latch} = '0;
    {port6_direction, port6_alt, port6_latch, ext_irq_edge_0, ext_irq_edge_1} = '0;
    {buzzer_out, serial3_clock_out, serial3_clock_oe, serial3_data_out} = '0;
    {serial1_data_out, serial1_clock_out, serial1_clock_oe, pwm_enable, pwm_out_1} = '0;
    {display_lo, display_hi, ext0, ext2, ext5, ext6} = '0;
    n0 = 0;
    n1 = 0;
    #2;
    t_reset();
    t_port0();
    t_port0_alt();
    t_irq();
    t_port2();
    t_open_drain();
    summarize();
  end
endmodule // tb_ppm_pin_mux

`default_nettype wire
